// file: design/pms_pkg.sv
// Constants shared by the power-mode and port-select sequencer.
package pms_pkg;

    // Master clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Hold time after the supply crosses its threshold, in milliseconds.
    localparam int unsigned HOLD_TIME_MS = 26;
    localparam int unsigned HOLD_CYCLES =
        (HOLD_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // Longest allowed sleep-to-normal transition, in milliseconds.
    localparam int unsigned WAKE_LIMIT_MS = 40;
    localparam int unsigned WAKE_LIMIT_CYCLES =
        (WAKE_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

    // Default transition length in cycles, well inside the limit.
    localparam int unsigned WAKE_CYCLES_DEFAULT = 1000;

    // Field positions in the status, mask and lock registers.
    localparam int unsigned RESET_DONE_BIT = 15;
    localparam int unsigned LOCK_TWO_WIRE_BIT = 1;

    // Number of select-pin falling edges that choose SPI.
    localparam logic [1:0] SPI_SELECT_EDGES = 2'h3;

    // Pin level of the mode-select pin for each power state.
    localparam logic MODE_PIN_NORMAL = 1'h0;
    localparam logic MODE_PIN_SLEEP = 1'h1;

    // Run control value that starts the signal processor.
    localparam logic [15:0] RUN_START = 16'h0001;

    // Reset values.
    localparam logic [7:0] LOCK_CFG_RESET = 8'h00;
    localparam logic [15:0] RUN_RESET = 16'h0000;

    // Counter width wide enough for the hold time.
    localparam int unsigned CNT_W = 24;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_HOLD  = 3'h1,
        ST_SLEEP = 3'h2,
        ST_WAKE  = 3'h3,
        ST_RUN   = 3'h4
    } pms_state_t;

endpackage : pms_pkg

// file: design/pms_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ps

module pms_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q  <= INIT;
            pinSync <= INIT;
        end
        else
        begin
            meta_q  <= pinIn;
            pinSync <= meta_q;
        end
    end

endmodule : pms_sync

// file: design/pms_sequencer.sv
// Power-mode sequencer, reset-done event and host serial port selection.
// Operation
// - Mode pin low selects normal state, high selects sleep state.
// - Sleep-to-normal resets control registers, keeps port-lock register.
// - First power-up entry into normal resets everything, port-lock included.
// - Transition end drives event line one low and sets reset-done bit 15.
// - Writing status word one with bit 15 set clears flag, releases line.
// - Reset-done is unmaskable; mask bit 15 has no effect.
// - In sleep, serial and fast capture ports do not respond.
// - Stay inactive 26 ms after the supply crosses its threshold.
// - Power-up always lands in sleep until the mode pin goes low.
// - Sleep-to-normal completes in under 40 ms.
// - Entering normal without a lock makes the two-wire bus active.
// - Three select falling edges switch the host port to SPI.
// - Lock bit 1 written pins the two-wire port; select toggles ignored.
// - Any lock-register write while SPI is active locks SPI.
// - Only power loss or reset pin low clear a port lock.
// - A locked port choice survives every sleep-normal state change.
// - Processor stays idle after a transition until run written 0x0001.
// - Supply below threshold forces inactive state, stopping all work.
// - Both event request outputs are active-low logic outputs.
`timescale 1ns/1ps

module pms_sequencer #(
    parameter int unsigned HOLD_CYCLES = pms_pkg::HOLD_CYCLES,
    parameter int unsigned WAKE_CYCLES = pms_pkg::WAKE_CYCLES_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        supplyOk,
    input  wire logic        powerModeSelectPin,
    input  wire logic        selectOrCaptureActivePin,
    input  wire logic        resetPinN,
    input  wire logic        statusOneWrite,
    input  wire logic [31:0] statusOneWdata,
    input  wire logic        maskOneWrite,
    input  wire logic [31:0] maskOneWdata,
    input  wire logic        lockCfgWrite,
    input  wire logic [7:0]  lockCfgWdata,
    input  wire logic        runWrite,
    input  wire logic [15:0] runWdata,
    input  wire logic        pendingEventZero,
    output logic             eventRequestLineOneN,
    output logic             eventRequestLineZeroN,
    output logic             normalPowerState,
    output logic             sleepState,
    output logic             resetDoneFlag,
    output logic [31:0]      maskOne,
    output logic [7:0]       portLockConfig,
    output logic             spiActive,
    output logic             portLocked,
    output logic             serialPortsEnable,
    output logic             ctrlRegsReset,
    output logic             processorRun
);

    localparam int unsigned W = pms_pkg::CNT_W;

    // Synchronised pins: mode, select, reset (reset pin idles high).
    logic [2:0] pinSync;

    pms_sync #(
        .WIDTH (3),
        .INIT  (3'h7)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   ({resetPinN, selectOrCaptureActivePin,
                   powerModeSelectPin}),
        .pinSync (pinSync)
    );

    wire modeSleep = (pinSync[0] == pms_pkg::MODE_PIN_SLEEP);
    wire selSync   = pinSync[1];
    wire rstPinLow = ~pinSync[2];

    logic supplyMeta_q;
    logic supplyOk_q;
    pms_pkg::pms_state_t state_q;
    pms_pkg::pms_state_t state_d;
    logic [W-1:0]        cnt_q;
    logic [W-1:0]        cnt_d;
    logic                firstEntry_q;
    logic                selPrev_q;
    logic [1:0]          edgeCnt_q;
    logic [15:0]         runReg_q;

    // Supply monitor level from the analog domain is synchronised too.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            supplyMeta_q <= 1'h0;
            supplyOk_q   <= 1'h0;
        end
        else
        begin
            supplyMeta_q <= supplyOk;
            supplyOk_q   <= supplyMeta_q;
        end
    end

    wire holdDone  = (cnt_q == W'(HOLD_CYCLES - 1));
    wire wakeDone  = (cnt_q == W'(WAKE_CYCLES - 1));
    wire inRun     = (state_q == pms_pkg::ST_RUN);
    wire wakeEnd   = (state_q == pms_pkg::ST_WAKE) && wakeDone;
    wire hwReset   = inRun && rstPinLow;

    // Next state of the sequencer.
    always_comb
    begin
        state_d = state_q;
        cnt_d   = '0;
        case (state_q)
            pms_pkg::ST_OFF:
            begin
                if (supplyOk_q)
                    state_d = pms_pkg::ST_HOLD;
            end
            pms_pkg::ST_HOLD:
            begin
                cnt_d = cnt_q + W'(1);
                if (holdDone)
                    state_d = pms_pkg::ST_SLEEP;
            end
            pms_pkg::ST_SLEEP:
            begin
                if (!modeSleep)
                    state_d = pms_pkg::ST_WAKE;
            end
            pms_pkg::ST_WAKE:
            begin
                cnt_d = cnt_q + W'(1);
                if (wakeDone)
                    state_d = pms_pkg::ST_RUN;
            end
            pms_pkg::ST_RUN:
            begin
                if (modeSleep)
                    state_d = pms_pkg::ST_SLEEP;
                else if (rstPinLow)
                    state_d = pms_pkg::ST_WAKE;
            end
            default:
            begin
                state_d = pms_pkg::ST_OFF;
            end
        endcase
        if (!supplyOk_q)
        begin
            state_d = pms_pkg::ST_OFF;
            cnt_d   = '0;
        end
    end

    // State register and transition counter.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= pms_pkg::ST_OFF;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // First entry after power-up clears the lock register as well.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !supplyOk_q)
            firstEntry_q <= 1'h1;
        else if (wakeEnd)
            firstEntry_q <= 1'h0;
    end

    wire fullReset = !supplyOk_q || hwReset
                     || (wakeEnd && firstEntry_q);

    wire selFall   = selPrev_q && !selSync;
    wire countSel  = inRun && !portLocked && !spiActive;

    // Select-pin falling edge counter and active port choice.
    always_ff @(posedge clk)
    begin
        if (sys_rst || fullReset)
        begin
            selPrev_q <= 1'h1;
            edgeCnt_q <= 2'h0;
            spiActive <= 1'h0;
        end
        else
        begin
            selPrev_q <= selSync;
            if (wakeEnd && !portLocked)
            begin
                edgeCnt_q <= 2'h0;
                spiActive <= 1'h0;
            end
            else if (countSel && selFall)
            begin
                edgeCnt_q <= edgeCnt_q + 2'h1;
                if (edgeCnt_q == pms_pkg::SPI_SELECT_EDGES - 2'h1)
                    spiActive <= 1'h1;
            end
        end
    end

    // Port-lock register survives sleep; only a full reset clears it.
    always_ff @(posedge clk)
    begin
        if (sys_rst || fullReset)
        begin
            portLockConfig <= pms_pkg::LOCK_CFG_RESET;
            portLocked     <= 1'h0;
        end
        else if (lockCfgWrite && inRun)
        begin
            portLockConfig <= lockCfgWdata;
            if (spiActive)
                portLocked <= 1'h1;
            else if (lockCfgWdata[pms_pkg::LOCK_TWO_WIRE_BIT])
                portLocked <= 1'h1;
        end
    end

    wire clrDone = statusOneWrite && inRun
                   && statusOneWdata[pms_pkg::RESET_DONE_BIT];

    // Reset-done flag: low through a transition, set as the transition ends.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            resetDoneFlag <= 1'h0;
        else if (wakeEnd)
            resetDoneFlag <= 1'h1;
        else if (!inRun || clrDone)
            resetDoneFlag <= 1'h0;
    end

    // Flag set at the wake end is seen by the flop one cycle later.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            eventRequestLineOneN <= 1'h1;
        else
            eventRequestLineOneN <= !(resetDoneFlag && !clrDone);
    end

    // Event line zero mirrors the pending event from elsewhere.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !inRun)
            eventRequestLineZeroN <= 1'h1;
        else
            eventRequestLineZeroN <= !pendingEventZero;
    end

    // Mask register has no hold on reset-done; reset on every wake.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !inRun)
            maskOne <= '0;
        else if (maskOneWrite)
            maskOne <= maskOneWdata;
    end

    // Run control: processor idle until software writes the start value.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !inRun)
            runReg_q <= pms_pkg::RUN_RESET;
        else if (runWrite)
            runReg_q <= runWdata;
    end

    // Status outputs, registered.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            normalPowerState  <= 1'h0;
            sleepState        <= 1'h0;
            serialPortsEnable <= 1'h0;
            ctrlRegsReset     <= 1'h1;
            processorRun      <= 1'h0;
        end
        else
        begin
            normalPowerState  <= (state_d == pms_pkg::ST_RUN);
            sleepState        <= (state_d == pms_pkg::ST_SLEEP);
            serialPortsEnable <= (state_d == pms_pkg::ST_RUN);
            ctrlRegsReset     <= (state_d != pms_pkg::ST_RUN);
            processorRun      <= inRun && (runReg_q == pms_pkg::RUN_START)
                                 && supplyOk_q;
        end
    end

endmodule : pms_sequencer

// file: test/pms_sequencer_sva.sv
// Checker for the power-mode sequencer port behaviour.
`timescale 1ns/1ps

module pms_sequencer_sva #(
    parameter int unsigned HOLD_CYCLES = 20,
    parameter int unsigned WAKE_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        supplyOk,
    input wire logic        resetPinN,
    input wire logic        statusOneWrite,
    input wire logic [31:0] statusOneWdata,
    input wire logic        runWrite,
    input wire logic [15:0] runWdata,
    input wire logic        eventRequestLineOneN,
    input wire logic        normalPowerState,
    input wire logic        sleepState,
    input wire logic        resetDoneFlag,
    input wire logic        spiActive,
    input wire logic        portLocked,
    input wire logic        serialPortsEnable,
    input wire logic        processorRun
);
    // Slack above the wake count; the pin synchronisers act before sleep falls.
    localparam int WAKE_MAX = WAKE_CYCLES + 8;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Flag stands the cycle after normal rises, the line one cycle later.
    sequence s_done_seen;
        ##1 resetDoneFlag ##1 !eventRequestLineOneN;
    endsequence

    // Reset pin high for three samples and supply high now and two samples back leave the lock untouched.
    sequence s_pins_quiet;
        resetPinN && $past(resetPinN) && $past(resetPinN, 2)
            && supplyOk && $past(supplyOk, 2);
    endsequence

    line_follow_a: assert property (
        !$past(sys_rst) |-> eventRequestLineOneN == !($past(resetDoneFlag)
            && !$past(statusOneWrite && statusOneWdata[15]
            && normalPowerState)))
        else $error("event line one does not follow flag");
    sleep_quiet_a: assert property (
        sleepState |-> !normalPowerState && !serialPortsEnable)
        else $error("sleep state not quiet");
    wake_done_a: assert property (
        $rose(normalPowerState) |-> s_done_seen)
        else $error("done event missing after wake");
    done_clear_a: assert property (
        statusOneWrite && statusOneWdata[15] && resetDoneFlag
            && normalPowerState |=> !resetDoneFlag)
        else $error("done flag not cleared");
    wake_bound_a: assert property (
        $fell(sleepState) && supplyOk |-> ##[1:WAKE_MAX] normalPowerState)
        else $error("wake took too long");
    run_idle_a: assert property (
        $rose(normalPowerState) |-> !processorRun)
        else $error("processor running after transition");
    run_start_a: assert property (
        $rose(processorRun) |-> $past(runWrite, 2)
            && $past(runWdata, 2) == 16'h0001)
        else $error("processor started without run write");
    spi_gate_a: assert property (
        $rose(spiActive) |-> !$past(portLocked) && $past(normalPowerState))
        else $error("spi selected while locked");
    lock_keep_a: assert property (
        portLocked ##0 s_pins_quiet |=> portLocked && $stable(spiActive))
        else $error("port lock lost");
    supply_loss_a: assert property (
        !supplyOk [*4] |-> !normalPowerState && !processorRun)
        else $error("active without supply");
endmodule : pms_sequencer_sva

bind pms_sequencer pms_sequencer_sva #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
) u_sva (.clk, .sys_rst, .supplyOk, .resetPinN, .statusOneWrite,
    .statusOneWdata, .runWrite, .runWdata, .eventRequestLineOneN,
    .normalPowerState, .sleepState, .resetDoneFlag, .spiActive,
    .portLocked, .serialPortsEnable, .processorRun);

// file: test/pms_host_model.sv
// Host processor model driving the mode, select and reset pins.
`timescale 1ns/1ps

module pms_host_model (
    input  wire logic clk,
    output logic      powerModeSelectPin,
    output logic      selectOrCaptureActivePin,
    output logic      resetPinN
);
    // Pins idle high; the mode pin is pulled up, so power-up is asleep.
    initial
    begin
        powerModeSelectPin = 1'h1;
        selectOrCaptureActivePin = 1'h1;
        resetPinN = 1'h1;
    end

    // Drives the mode pin: low asks for normal, high for sleep.
    task set_mode(input logic sleep);
        @(posedge clk);
        #1;
        powerModeSelectPin = sleep;
    endtask : set_mode

    // Three falling select edges, each level held past the synchroniser.
    task select_spi();
        repeat (3)
        begin
            @(posedge clk);
            #1;
            selectOrCaptureActivePin = 1'h0;
            repeat (4) @(posedge clk);
            #1;
            selectOrCaptureActivePin = 1'h1;
            repeat (4) @(posedge clk);
        end
    endtask : select_spi

    // Low pulse on the reset pin, long enough to pass the synchroniser.
    task pulse_reset();
        @(posedge clk);
        #1;
        resetPinN = 1'h0;
        repeat (8) @(posedge clk);
        #1;
        resetPinN = 1'h1;
    endtask : pulse_reset
endmodule : pms_host_model

// file: test/tb_pms_sequencer.sv
// Self-checking testbench for the power-mode sequencer.
`timescale 1ns/1ps

module tb_pms_sequencer;
    logic        clk, sys_rst, supplyOk, pendingEventZero;
    logic        statusOneWrite, maskOneWrite, lockCfgWrite, runWrite;
    logic [31:0] statusOneWdata, maskOneWdata, maskOne;
    logic [7:0]  lockCfgWdata, portLockConfig;
    logic [15:0] runWdata;
    logic        powerModeSelectPin, selectOrCaptureActivePin, resetPinN;
    logic        eventRequestLineOneN, eventRequestLineZeroN;
    logic        normalPowerState, sleepState, resetDoneFlag;
    logic        spiActive, portLocked, serialPortsEnable;
    logic        ctrlRegsReset, processorRun;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          i;
    // Mask rows: value written beside the mask expected back.
    logic [31:0] rows [3][2] = '{'{32'h0000_8000, 32'h0000_8000},
        '{32'hFFFF_FFFF, 32'hFFFF_FFFF}, '{32'h0000_0000, 32'h0000_0000}};

    pms_sequencer #(.HOLD_CYCLES(20), .WAKE_CYCLES(10)) DUT (.clk,
        .sys_rst, .supplyOk, .powerModeSelectPin, .selectOrCaptureActivePin,
        .resetPinN, .statusOneWrite, .statusOneWdata, .maskOneWrite,
        .maskOneWdata, .lockCfgWrite, .lockCfgWdata, .runWrite, .runWdata,
        .pendingEventZero, .eventRequestLineOneN, .eventRequestLineZeroN,
        .normalPowerState, .sleepState, .resetDoneFlag, .maskOne,
        .portLockConfig, .spiActive, .portLocked, .serialPortsEnable,
        .ctrlRegsReset, .processorRun);

    pms_host_model host (.clk, .powerModeSelectPin,
        .selectOrCaptureActivePin, .resetPinN);

    // Prints the verdict and ends the run.
    task finish_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // Compares one value and reports a mismatch at once.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // Waits whole cycles, landing just after the edge.
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // One-cycle write strobe: 0 status, 1 mask, 2 lock, 3 run.
    task wr(input int k, input logic [31:0] d);
        tick(1);
        {statusOneWdata, maskOneWdata} = {d, d};
        {lockCfgWdata, runWdata} = {d[7:0], d[15:0]};
        {statusOneWrite, maskOneWrite} = {k == 0, k == 1};
        {lockCfgWrite, runWrite} = {k == 2, k == 3};
        tick(1);
        {statusOneWrite, maskOneWrite, lockCfgWrite, runWrite} = 4'h0;
    endtask : wr

    // Waits, bounded, for normal (1) or sleep (0) and checks it came.
    task wait_state(input logic nrm);
        for (i = 0; i < 60; i++)
        begin
            if ((nrm ? normalPowerState : sleepState) === 1'h1)
                break;
            tick(1);
        end
        check(nrm ? normalPowerState : sleepState, 1'h1);
    endtask : wait_state

    // Sleeps and wakes again through the mode pin.
    task nap();
        host.set_mode(1'h1);
        wait_state(1'h0);
        host.set_mode(1'h0);
        wait_state(1'h1);
    endtask : nap

    // Free-running master clock.
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short.
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // Main sequence.
    initial
    begin
        {sys_rst, supplyOk, pendingEventZero} = 3'h6;
        {statusOneWrite, maskOneWrite, lockCfgWrite, runWrite} = 4'h0;
        {statusOneWdata, maskOneWdata} = 64'h0;
        {lockCfgWdata, runWdata} = 24'h0;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        tick(20);
        check(sleepState, 1'h0);
        wait_state(1'h0);
        check(serialPortsEnable, 1'h0);
        host.set_mode(1'h0);
        tick(4);
        check(resetDoneFlag, 1'h0);
        wait_state(1'h1);
        check({processorRun, spiActive, portLockConfig}, 10'h000);
        check({serialPortsEnable, ctrlRegsReset}, 2'h2);
        tick(2);
        check({resetDoneFlag, eventRequestLineOneN}, 2'h2);
        for (int r = 0; r < 3; r++)
        begin
            wr(1, rows[r][0]);
            tick(1);
            check(maskOne, rows[r][1]);
            check(eventRequestLineOneN, 1'h0);
        end
        pendingEventZero = 1'h1;
        tick(2);
        check(eventRequestLineZeroN, 1'h0);
        wr(0, 32'hFFFF_FFFF);
        tick(1);
        check({resetDoneFlag, eventRequestLineOneN}, 2'h1);
        wr(3, 32'h0000_0001);
        tick(1);
        check(processorRun, 1'h1);
        wr(2, 32'h0000_0002);
        wr(1, 32'h0000_8000);
        host.select_spi();
        tick(3);
        check({portLocked, spiActive}, 2'h2);
        nap();
        check({portLocked, portLockConfig, processorRun}, 10'h204);
        check(maskOne, 32'h0000_0000);
        host.pulse_reset();
        wait_state(1'h1);
        check({portLocked, portLockConfig}, 9'h000);
        host.select_spi();
        tick(3);
        check(spiActive, 1'h1);
        wr(2, 32'h0000_0000);
        check(portLocked, 1'h1);
        nap();
        check({spiActive, portLocked}, 2'h3);
        supplyOk = 1'h0;
        tick(6);
        check({normalPowerState, processorRun}, 2'h0);
        sys_rst = 1'h1;
        tick(2);
        check({eventRequestLineOneN, ctrlRegsReset}, 2'h3);
        finish_test();
    end
endmodule : tb_pms_sequencer
